/* dv/sss_master_model.sv */
// ------------------------------------------------------------
// external synchronous master on the serial link
// ------------------------------------------------------------
module sss_master_model (
    // link pins toward the device
    output logic serial_clock_pin,
    output logic serial_data_in,
    // device drive of the data pin
    input wire logic serial_data_out,
    input wire logic serial_data_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic drv_en = 1'b0;
    logic drv_val = 1'b0;
    logic noise = 1'b0;
    // clock stands low between frames
    initial serial_clock_pin = 1'b0;
    // a released line keeps changing so a stale bit never passes
    always #7 noise = ~noise;
    // wire level: device drive wins, then ours, else noise
    assign serial_data_in = serial_data_oe ? serial_data_out : (drv_en ? drv_val : noise);
    // one eight-bit frame, lsb first, 80 ns period
    task automatic xfer(input logic [7:0] tx_byte, input logic drive, output logic [7:0] rx_byte);
        #1.3;
        for (int i = 0; i < 8; i++) begin
            #40 serial_clock_pin = 1'b1;
            drv_en = drive;
            drv_val = tx_byte[i];
            #40 rx_byte[i] = serial_data_in;
            serial_clock_pin = 1'b0;
        end
        #40 drv_en = 1'b0;
    endtask : xfer
endmodule : sss_master_model

/* dv/tb.sv */
// ------------------------------------------------------------
// self-checking bench for the sleep-mode slave serial port
// ------------------------------------------------------------
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    sss_pkg::sss_req_s req = '0;
    logic [7:0] rdata;
    logic serial_clock_pin;
    logic serial_data_in;
    logic serial_data_out;
    logic serial_data_oe;
    sss_pkg::sss_core_s core;
    logic irq;
    int err_total = 0;
    int check_count = 0;
    logic [7:0] lfsr = 8'h62;
    logic [7:0] rx_q[$];
    logic [7:0] got;
    logic [7:0] rd_v;
    logic [7:0] txb[3];

    // core clock, 5 ns
    initial forever #2.5 clk = ~clk;

    sss_top dut_u (
        .clk(clk), .rst_b(rst_b), .req(req), .rdata(rdata),
        .serial_clock_pin(serial_clock_pin), .serial_data_in(serial_data_in),
        .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
        .core(core), .irq(irq)
    );
    sss_master_model master_u (
        .serial_clock_pin(serial_clock_pin), .serial_data_in(serial_data_in),
        .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run
    function automatic logic [7:0] lfsr_step(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr_step
    // one-cycle write strobe
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask : reg_wr
    // one-cycle read strobe, data taken in the following cycle
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        req.rd <= 1'b0;
        #1 d = rdata;
    endtask : reg_rd
    task automatic settle();
        repeat (8) @(posedge clk);
        #1;
    endtask : settle
    // bounded wait on the wake level
    task automatic wait_wake(input logic exp);
        int n;
        n = 0;
        while (core.wake_req !== exp && n < 64) begin
            @(posedge clk);
            #1 n++;
        end
        if (core.wake_req !== exp) begin
            check(core.wake_req, exp);
            complete_run();
        end
    endtask : wait_wake

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        #1 check(core.isr_vector, sss_pkg::ISR_VECTOR);
        // reset values, unmapped 0x1C included
        for (int a = 0; a < 32; a += 4) begin
            reg_rd(8'(a), rd_v);
            // an empty holding register shows transmit-empty from reset on
            check(rd_v, (8'(a) == sss_pkg::ADDR_FLAGS) ? 8'h02 : 8'h00);
        end
        // clock master selected: shifters stay idle
        reg_wr(sss_pkg::ADDR_CTRL, 8'h07);
        master_u.xfer(8'hA5, 1'b1, got);
        settle();
        reg_rd(sss_pkg::ADDR_FLAGS, rd_v);
        check(rd_v, 8'h02);
        // slave receive with continuous receive clear and single receive set
        reg_wr(sss_pkg::ADDR_CTRL, 8'h23);
        reg_wr(sss_pkg::ADDR_IRQCTL, 8'h07);
        for (int n = 0; n < 3; n++) begin
            lfsr = lfsr_step(lfsr);
            if (rx_q.size() < 2) rx_q.push_back(lfsr);
            master_u.xfer(lfsr, 1'b1, got);
            wait_wake(1'b1);
        end
        settle();
        check(core.isr_req, 1'b1);
        check(irq, 1'b0);
        reg_wr(sss_pkg::ADDR_MASK, 8'h07);
        settle();
        check(irq, 1'b1);
        reg_rd(sss_pkg::ADDR_STATUS, rd_v);
        check(rd_v, 8'h05);
        reg_rd(sss_pkg::ADDR_STATUS, rd_v);
        check(rd_v, 8'h00);
        settle();
        check(irq, 1'b0);
        // drain the receive buffer, then one read of an empty buffer
        while (rx_q.size() > 0) begin
            reg_rd(sss_pkg::ADDR_RXDATA, rd_v);
            check(rd_v, rx_q.pop_front());
        end
        reg_rd(sss_pkg::ADDR_RXDATA, rd_v);
        check(rd_v, 8'h00);
        settle();
        reg_rd(sss_pkg::ADDR_FLAGS, rd_v);
        check(rd_v, 8'h02);
        check(core.wake_req, 1'b0);
        // slave transmit, global enable clear
        reg_wr(sss_pkg::ADDR_CTRL, 8'h0B);
        reg_wr(sss_pkg::ADDR_IRQCTL, 8'h0A);
        for (int n = 0; n < 3; n++) begin
            lfsr = lfsr_step(lfsr);
            txb[n] = lfsr;
        end
        reg_wr(sss_pkg::ADDR_TXDATA, txb[0]);
        reg_wr(sss_pkg::ADDR_TXDATA, txb[1]);
        settle();
        check(serial_data_oe, 1'b1);
        reg_rd(sss_pkg::ADDR_FLAGS, rd_v);
        check(rd_v, 8'h00);
        check(core.wake_req, 1'b0);
        master_u.xfer(8'h00, 1'b0, got);
        check(got, txb[0]);
        wait_wake(1'b1);
        reg_rd(sss_pkg::ADDR_FLAGS, rd_v);
        check(rd_v, 8'h02);
        check(core.isr_req, 1'b0);
        reg_wr(sss_pkg::ADDR_TXDATA, txb[2]);
        settle();
        reg_rd(sss_pkg::ADDR_FLAGS, rd_v);
        check(rd_v, 8'h00);
        for (int n = 1; n < 3; n++) begin
            master_u.xfer(8'h00, 1'b0, got);
            check(got, txb[n]);
        end
        settle();
        reg_rd(sss_pkg::ADDR_STATUS, rd_v);
        check(rd_v, 8'h02);
        complete_run();
    end
endmodule : tb

/* rtl/sss_pkg.sv */
package sss_pkg;
    // ------------------------------------------------------------
    // register map, byte addresses on the 8-bit register port
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00; // receive_control_reg / transmit_control_reg
    localparam logic [7:0] ADDR_IRQCTL = 8'h04; // irq_control_reg and peripheral_irq_enable_one
    localparam logic [7:0] ADDR_RXDATA = 8'h08; // receive_holding_reg, read pops
    localparam logic [7:0] ADDR_TXDATA = 8'h0C; // transmit_holding_reg, write only
    localparam logic [7:0] ADDR_STATUS = 8'h10; // sticky events, read clears
    localparam logic [7:0] ADDR_MASK = 8'h14; // mask, same layout as status
    localparam logic [7:0] ADDR_FLAGS = 8'h18; // peripheral_irq_flags_one, read only

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTRL_PORT_ENABLE = 0;
    localparam int CTRL_SYNC_MODE = 1;
    localparam int CTRL_CLOCK_MASTER = 2;
    localparam int CTRL_TX_ENABLE = 3;
    localparam int CTRL_CONT_RX = 4; // continuous_receive_enable, treated as set in slave mode
    localparam int CTRL_SINGLE_RX = 5; // single_receive_enable, ignored in slave mode
    localparam int IRQ_GLOBAL = 0; // global_irq_enable
    localparam int IRQ_PERIPH_GATE = 1; // peripheral_irq_gate
    localparam int IRQ_RX_ENABLE = 2; // receive_irq_enable
    localparam int IRQ_TX_ENABLE = 3; // transmit_irq_enable
    localparam int FLAG_RX_DONE = 0; // receive_done_flag
    localparam int FLAG_TX_EMPTY = 1; // transmit_empty_flag
    localparam int EV_RX_WORD = 0;
    localparam int EV_TX_LOAD = 1;
    localparam int EV_OVERRUN = 2;

    // ------------------------------------------------------------
    // reset values and counts
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] IRQCTL_RESET = 8'h00;
    localparam logic [2:0] EV_RESET = 3'h0;
    localparam logic [2:0] BIT_LAST = 3'h7; // eight bits per word
    localparam logic [1:0] RX_DEPTH = 2'h2; // two-word receive buffer
    localparam logic [14:0] ISR_VECTOR = 15'h0004;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sss_req_s;

    typedef struct packed {
        logic wake_req;
        logic isr_req;
        logic [14:0] isr_vector;
    } sss_core_s;
endpackage : sss_pkg

/* rtl/sss_sync2.sv */
// two-flop synchroniser for levels from outside the clk domain
module sss_sync2 #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // level in and out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    // first stage is read only by the second
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta <= '0;
            sync_out <= '0;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule : sss_sync2

/* rtl/sss_top.sv */
module sss_top (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // register port
    input wire sss_pkg::sss_req_s req,
    output logic [7:0] rdata,
    // serial link pins
    input wire logic serial_clock_pin,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_oe,
    // core wake and interrupt
    output sss_pkg::sss_core_s core,
    output logic irq
);
    // ------------------------------------------------------------
    // pin synchronisation and edge finding
    // ------------------------------------------------------------
    logic ck_s;
    logic din_s;
    logic ck_q;
    logic ck_fall;

    sss_sync2 #(.WIDTH(2)) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .async_in({serial_clock_pin, serial_data_in}),
        .sync_out({ck_s, din_s})
    );

    // delayed copy of the synced clock for edge detection
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ck_q <= 1'b0;
        end else begin
            ck_q <= ck_s;
        end
    end

    // master samples and device shifts on the falling serial edge
    assign ck_fall = ck_q & ~ck_s;

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    logic [7:0] ctrl;
    logic [7:0] irqctl;
    logic [2:0] status;
    logic [2:0] mask;
    logic operational;
    logic tx_active;
    logic rx_active;

    // software writes to control and mask
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl <= sss_pkg::CTRL_RESET;
            irqctl <= sss_pkg::IRQCTL_RESET;
            mask <= sss_pkg::EV_RESET;
        end else if (req.wr) begin
            if (req.addr == sss_pkg::ADDR_CTRL) begin
                ctrl <= req.wdata;
            end else if (req.addr == sss_pkg::ADDR_IRQCTL) begin
                irqctl <= req.wdata;
            end else if (req.addr == sss_pkg::ADDR_MASK) begin
                mask <= req.wdata[2:0];
            end
        end
    end

    // only synchronous slave mode keeps the shifters alive
    assign operational = ctrl[sss_pkg::CTRL_PORT_ENABLE] & ctrl[sss_pkg::CTRL_SYNC_MODE]
                       & ~ctrl[sss_pkg::CTRL_CLOCK_MASTER];
    assign tx_active = operational & ctrl[sss_pkg::CTRL_TX_ENABLE];
    // receiver runs whenever not transmitting, enable bits are don't care
    assign rx_active = operational & ~ctrl[sss_pkg::CTRL_TX_ENABLE];

    // ------------------------------------------------------------
    // receive shifter and two-word buffer
    // ------------------------------------------------------------
    logic [7:0] rx_shift;
    logic [2:0] rx_cnt;
    logic [7:0] rx_mem [0:1];
    logic rx_wp;
    logic rx_rp;
    logic [1:0] rx_count;
    logic rx_word;
    logic rx_push;
    logic rx_pop;
    logic rx_over;
    logic rd_rx;

    assign rx_word = rx_active & ck_fall & (rx_cnt == sss_pkg::BIT_LAST);
    assign rx_push = rx_word & (rx_count != sss_pkg::RX_DEPTH);
    assign rx_over = rx_word & (rx_count == sss_pkg::RX_DEPTH);
    assign rd_rx = req.rd & (req.addr == sss_pkg::ADDR_RXDATA);
    assign rx_pop = rd_rx & (rx_count != 2'h0);

    // shift in lsb first on each falling serial edge
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_shift <= 8'h00;
            rx_cnt <= 3'h0;
        end else if (!rx_active) begin
            rx_cnt <= 3'h0;
        end else if (ck_fall) begin
            rx_shift <= {din_s, rx_shift[7:1]};
            rx_cnt <= rx_cnt + 3'h1;
        end
    end

    // buffer write pointer
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_wp <= 1'b0;
        end else if (rx_push) begin
            rx_wp <= ~rx_wp;
        end
    end

    // buffer storage, the finished word goes in with its last bit, no reset needed
    always_ff @(posedge clk) begin
        if (rx_push) begin
            rx_mem[rx_wp] <= {din_s, rx_shift[7:1]};
        end
    end

    // buffer read side and fill level
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_rp <= 1'b0;
            rx_count <= 2'h0;
        end else begin
            if (rx_pop) begin
                rx_rp <= ~rx_rp;
            end
            // flag clears only when reads empty the buffer
            if (rx_push && !rx_pop) begin
                rx_count <= rx_count + 2'h1;
            end else if (rx_pop && !rx_push) begin
                rx_count <= rx_count - 2'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // transmit holding register and shifter
    // ------------------------------------------------------------
    logic [7:0] tx_hold;
    logic hold_full;
    logic [7:0] tx_shift;
    logic shift_full;
    logic [2:0] tx_cnt;
    logic tx_load;
    logic wr_tx;
    logic tx_take;

    assign tx_load = hold_full & ~shift_full & tx_active;
    assign wr_tx = req.wr & (req.addr == sss_pkg::ADDR_TXDATA);
    // a write to a full holding register is dropped unless its byte moves to the shifter in that cycle
    assign tx_take = wr_tx & (~hold_full | tx_load);

    // holding register, a new byte wins over the move to the shifter
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_hold <= 8'h00;
            hold_full <= 1'b0;
        end else if (tx_take) begin
            tx_hold <= req.wdata;
            hold_full <= 1'b1;
        end else if (tx_load) begin
            hold_full <= 1'b0;
        end
    end

    // shifter, bit 0 drives the pin and advances on falling edges
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_shift <= 8'h00;
            shift_full <= 1'b0;
            tx_cnt <= 3'h0;
        end else if (!tx_active) begin
            shift_full <= 1'b0;
            tx_cnt <= 3'h0;
        end else if (shift_full && ck_fall) begin
            tx_shift <= {1'b0, tx_shift[7:1]};
            tx_cnt <= tx_cnt + 3'h1;
            if (tx_cnt == sss_pkg::BIT_LAST) begin
                shift_full <= 1'b0;
            end
        end else if (tx_load) begin
            tx_shift <= tx_hold;
            shift_full <= 1'b1;
        end
    end

    assign serial_data_out = tx_shift[0];

    // pin driven only while transmitting
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            serial_data_oe <= 1'b0;
        end else begin
            serial_data_oe <= tx_active;
        end
    end

    // ------------------------------------------------------------
    // events, status and interrupt line
    // ------------------------------------------------------------
    logic [2:0] events;
    logic rd_status;
    logic rx_flag;
    logic tx_flag;

    assign events = {rx_over, tx_load, rx_push};
    assign rd_status = req.rd & (req.addr == sss_pkg::ADDR_STATUS);
    assign rx_flag = (rx_count != 2'h0);
    assign tx_flag = ~hold_full;

    // sticky events, a set in the clearing read survives
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            status <= sss_pkg::EV_RESET;
        end else begin
            status <= (rd_status ? sss_pkg::EV_RESET : status) | events;
        end
    end

    // level interrupt from unmasked status
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & mask);
        end
    end

    // wake from the enabled flags, vector request only with global enable
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            core <= '0;
        end else begin
            core.wake_req <= irqctl[sss_pkg::IRQ_PERIPH_GATE]
                & ((rx_flag & irqctl[sss_pkg::IRQ_RX_ENABLE])
                | (tx_flag & irqctl[sss_pkg::IRQ_TX_ENABLE]));
            core.isr_req <= irqctl[sss_pkg::IRQ_GLOBAL] & irqctl[sss_pkg::IRQ_PERIPH_GATE]
                & ((rx_flag & irqctl[sss_pkg::IRQ_RX_ENABLE])
                | (tx_flag & irqctl[sss_pkg::IRQ_TX_ENABLE]));
            core.isr_vector <= sss_pkg::ISR_VECTOR;
        end
    end

    // ------------------------------------------------------------
    // read data, one cycle after the strobe
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= 8'h00;
        end else if (req.rd) begin
            if (req.addr == sss_pkg::ADDR_CTRL) begin
                rdata <= ctrl;
            end else if (req.addr == sss_pkg::ADDR_IRQCTL) begin
                rdata <= irqctl;
            end else if (req.addr == sss_pkg::ADDR_RXDATA) begin
                rdata <= rx_flag ? rx_mem[rx_rp] : 8'h00;
            end else if (req.addr == sss_pkg::ADDR_STATUS) begin
                rdata <= {5'h00, status};
            end else if (req.addr == sss_pkg::ADDR_MASK) begin
                rdata <= {5'h00, mask};
            end else if (req.addr == sss_pkg::ADDR_FLAGS) begin
                rdata <= {6'h00, tx_flag, rx_flag};
            end else begin
                rdata <= 8'h00;
            end
        end else begin
            rdata <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_rx_sample;
        @(posedge clk) disable iff (!rst_b)
        (rx_active && ck_fall) |=> (rx_shift[7] == $past(din_s));
    endproperty
    a_rx_sample: assert property (p_rx_sample) else $error("rx bit not sampled");

    property p_rx_done;
        @(posedge clk) disable iff (!rst_b)
        (rx_push && !rx_pop && rx_count == 2'h0) |=> (rx_count == 2'h1)
            ##1 (core.wake_req || !(irqctl[sss_pkg::IRQ_RX_ENABLE] && irqctl[sss_pkg::IRQ_PERIPH_GATE]));
    endproperty
    a_rx_done: assert property (p_rx_done) else $error("rx word did not set flag");

    property p_rx_drain;
        @(posedge clk) disable iff (!rst_b)
        (rx_pop && !rx_push && rx_count == 2'h1) |=> (rx_count == 2'h0);
    endproperty
    a_rx_drain: assert property (p_rx_drain) else $error("flag not cleared by last read");

    property p_tx_shift;
        @(posedge clk) disable iff (!rst_b)
        (tx_active && shift_full && ck_fall) |=> (tx_shift[6:0] == $past(tx_shift[7:1]));
    endproperty
    a_tx_shift: assert property (p_tx_shift) else $error("tx shifter did not advance");

    property p_tx_load;
        @(posedge clk) disable iff (!rst_b)
        tx_load |=> (tx_shift == $past(tx_hold)) && shift_full && status[sss_pkg::EV_TX_LOAD];
    endproperty
    a_tx_load: assert property (p_tx_load) else $error("holding byte not moved");

    property p_tx_write;
        @(posedge clk) disable iff (!rst_b)
        tx_take |=> hold_full && (tx_hold == $past(req.wdata));
    endproperty
    a_tx_write: assert property (p_tx_write) else $error("write did not clear empty");

    property p_mode_idle;
        @(posedge clk) disable iff (!rst_b)
        !operational |=> !shift_full && (rx_cnt == 3'h0) && !serial_data_oe;
    endproperty
    a_mode_idle: assert property (p_mode_idle) else $error("shifter active outside slave mode");

    property p_isr;
        @(posedge clk) disable iff (!rst_b)
        core.isr_req |-> core.wake_req && (core.isr_vector == sss_pkg::ISR_VECTOR);
    endproperty
    a_isr: assert property (p_isr) else $error("isr request without wake");

    property p_clear_loses;
        @(posedge clk) disable iff (!rst_b)
        (rd_status && events != 3'h0) |=> ((status & $past(events)) == $past(events));
    endproperty
    a_clear_loses: assert property (p_clear_loses) else $error("event lost in clearing read");

    c_rx_word: cover property (@(posedge clk) disable iff (!rst_b) rx_push);
    c_tx_load: cover property (@(posedge clk) disable iff (!rst_b) tx_load ##[1:200] tx_load);
    c_overrun: cover property (@(posedge clk) disable iff (!rst_b) rx_over);
    c_isr: cover property (@(posedge clk) disable iff (!rst_b) core.isr_req && irq);
endmodule : sss_top
